// *** common/adc_result_buffer_params.svh ***
`ifndef ADC_RESULT_BUFFER_PARAMS_SVH
`define ADC_RESULT_BUFFER_PARAMS_SVH

// register byte offsets
`define OFF_CONTROL_TWO 8'h00
`define OFF_CHANNEL_SELECT 8'h04
`define OFF_SCAN_SELECT 8'h08
`define OFF_IRQ_STATUS 8'h0C
`define OFF_IRQ_MASK 8'h10
`define OFF_SLOT_BASE 8'h40

// control register fields
`define POS_REF_SELECT 13
`define POS_OFFSET_CAL 12
`define POS_PER_CHANNEL 11
`define POS_SCAN_ENABLE 10
`define POS_FILL_STATUS 7
`define POS_SEQ_PER_IRQ 2
`define POS_SPLIT_MODE 1
`define CONTROL_WRITE_MASK 32'h0000FC3E
`define CONTROL_RESET 32'h00000000

// interrupt status bits
`define IRQ_SEQ_DONE 0
`define IRQ_SLOT_DROP 1
`define IRQ_BITS 2

// storage layout
`define SLOT_COUNT 22
`define HALF_COUNT 11

`endif

// *** common/adc_result_buffer_pkg.sv ***
package adc_result_buffer_pkg;

  typedef logic [2:0] ref_code_type;
  typedef logic [4:0] slot_index_type;
  typedef logic [3:0] seq_count_type;

endpackage

// *** verilog/adc_result_buffer_control.sv ***
// Contract
// - Control bits 15..13 pick the positive and negative references, codes 1xx being reserved.
// - With offset calibration set both sample-and-hold inputs go to the negative reference, else they follow channel and scan selection.
// - With the per-channel bit set a result lands in the slot of its channel, otherwise storage acts as a queue.
// - In split mode the fill status reads 1 while slots 11-21 fill and 0 while slots 0-10 fill.
// - Bits 5..2 give the sequences counted before an interrupt, code 0000 meaning every sequence.
// - Split mode makes two 11-word halves, otherwise one 22-word buffer.
// - Control bits 31..16, 9..8, 6 and 0 ignore writes and read zero.
`timescale 1ns/1ps
`include "adc_result_buffer_params.svh"

module adc_result_buffer_control
  import adc_result_buffer_pkg::*;
#(
  parameter int RESULT_WIDTH = 32
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic conv_done,
  input wire logic [4:0] conv_channel,
  input wire logic [RESULT_WIDTH-1:0] conv_result,
  output logic ref_pos_external,
  output logic ref_neg_external,
  output logic sample_inputs_to_neg_ref,
  output logic [4:0] primary_positive_input,
  output logic irq
);

  logic [31:0] converter_control_two;
  logic [31:0] channel_select_register;
  logic [31:0] scan_select_register;
  logic [`IRQ_BITS-1:0] irq_status;
  logic [`IRQ_BITS-1:0] irq_mask;
  logic [RESULT_WIDTH-1:0] result_slot [`SLOT_COUNT];
  logic buffer_fill_status;
  seq_count_type seq_count;
  slot_index_type fill_ptr;
  slot_index_type scan_index;

  ref_code_type reference_select;
  logic offset_calibration_enable;
  logic per_channel_buffer_enable;
  logic input_scan_enable;
  seq_count_type sequences_per_interrupt;
  logic split_buffer_mode;

  logic wr_control;
  logic seq_end;
  logic slot_write;
  logic slot_drop;
  slot_index_type wr_slot;
  slot_index_type region_last;
  slot_index_type rd_slot;
  logic [7:0] rd_offset;
  logic [31:0] control_view;

  assign reference_select = converter_control_two[`POS_REF_SELECT +: 3];
  assign offset_calibration_enable = converter_control_two[`POS_OFFSET_CAL];
  assign per_channel_buffer_enable = converter_control_two[`POS_PER_CHANNEL];
  assign input_scan_enable = converter_control_two[`POS_SCAN_ENABLE];
  assign sequences_per_interrupt =
    converter_control_two[`POS_SEQ_PER_IRQ +: 4];
  assign split_buffer_mode = converter_control_two[`POS_SPLIT_MODE];
  assign wr_control = reg_write && reg_addr == `OFF_CONTROL_TWO;

  // fill status lives outside the stored word so software cannot write it
  always_comb
  begin
    control_view = converter_control_two;
    control_view[`POS_FILL_STATUS] = buffer_fill_status;
  end

  // sequence boundary: code 0000 ends a sequence on every conversion
  assign seq_end = conv_done && seq_count == sequences_per_interrupt;

  // last queue pointer offset of the region being filled, 10 in split mode even while slots 11-21 fill
  assign region_last = split_buffer_mode ?
    5'(`HALF_COUNT - 1) : 5'(`SLOT_COUNT - 1);

  always_comb
  begin
    if (per_channel_buffer_enable)
    begin
      wr_slot = conv_channel;
    end
    else if (split_buffer_mode && buffer_fill_status)
    begin
      wr_slot = 5'(`HALF_COUNT) + fill_ptr;
    end
    else
    begin
      wr_slot = fill_ptr;
    end
  end

  // a channel past the last slot has nowhere to go and is dropped
  assign slot_drop = conv_done && wr_slot >= 5'(`SLOT_COUNT);
  assign slot_write = conv_done && !slot_drop;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      converter_control_two <= `CONTROL_RESET;
    end
    else if (wr_control)
    begin
      converter_control_two <= reg_wdata & `CONTROL_WRITE_MASK;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      channel_select_register <= 32'h00000000;
      scan_select_register <= 32'h00000000;
      irq_mask <= '0;
    end
    else if (reg_write)
    begin
      if (reg_addr == `OFF_CHANNEL_SELECT)
        channel_select_register <= {27'h0, reg_wdata[4:0]};
      if (reg_addr == `OFF_SCAN_SELECT)
        scan_select_register <= reg_wdata;
      if (reg_addr == `OFF_IRQ_MASK)
        irq_mask <= reg_wdata[`IRQ_BITS-1:0];
    end
  end

  // sequence counter restarts when the rate is reprogrammed
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      seq_count <= '0;
    else if (wr_control || seq_end)
      seq_count <= '0;
    else if (conv_done)
      seq_count <= seq_count + 4'h1;
  end

  // queue pointer: rewinds at every interrupt boundary so each batch
  // starts at the head of its region
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      fill_ptr <= '0;
    else if (wr_control || seq_end)
      fill_ptr <= '0;
    else if (conv_done && !per_channel_buffer_enable)
      fill_ptr <= (fill_ptr >= region_last) ? 5'h00 : fill_ptr + 5'h01;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      buffer_fill_status <= 1'b0;
    else if (!split_buffer_mode)
      buffer_fill_status <= 1'b0;
    else if (seq_end)
      buffer_fill_status <= !buffer_fill_status;
  end

  always_ff @(posedge clk)
  begin
    if (slot_write)
      result_slot[wr_slot] <= conv_result;
  end

  function automatic slot_index_type next_scan(input logic [31:0] mask,
                                               input slot_index_type cur);
    slot_index_type pick;
    slot_index_type cand;
    logic found;
    pick = cur;
    found = 1'b0;
    for (int k = 1; k <= 32; k++)
    begin
      cand = cur + 5'(k);
      if (!found && mask[cand])
      begin
        pick = cand;
        found = 1'b1;
      end
    end
    return pick;
  endfunction

  // scan advances after each conversion; an empty scan set holds position
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      scan_index <= '0;
    else if (input_scan_enable && conv_done)
      scan_index <= next_scan(scan_select_register, scan_index);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ref_pos_external <= 1'b0;
      ref_neg_external <= 1'b0;
    end
    else if (reference_select[2])
    begin
      // reserved codes fall back to the supply rails
      ref_pos_external <= 1'b0;
      ref_neg_external <= 1'b0;
    end
    else
    begin
      ref_pos_external <= reference_select[1];
      ref_neg_external <= reference_select[0];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sample_inputs_to_neg_ref <= 1'b0;
      primary_positive_input <= '0;
    end
    else
    begin
      sample_inputs_to_neg_ref <= offset_calibration_enable;
      primary_positive_input <= input_scan_enable ?
        scan_index : channel_select_register[4:0];
    end
  end

  // a new event beats a write-one-to-clear in the same cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq_status <= '0;
    else
    begin
      for (int b = 0; b < `IRQ_BITS; b++)
      begin
        if ((b == `IRQ_SEQ_DONE && seq_end) ||
            (b == `IRQ_SLOT_DROP && slot_drop))
          irq_status[b] <= 1'b1;
        else if (reg_write && reg_addr == `OFF_IRQ_STATUS && reg_wdata[b])
          irq_status[b] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_mask);
  end

  assign rd_offset = reg_addr - `OFF_SLOT_BASE;
  assign rd_slot = rd_offset[6:2];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 32'h00000000;
    else if (!reg_read)
      reg_rdata <= 32'h00000000;
    else if (reg_addr == `OFF_CONTROL_TWO)
      reg_rdata <= control_view;
    else if (reg_addr == `OFF_CHANNEL_SELECT)
      reg_rdata <= channel_select_register;
    else if (reg_addr == `OFF_SCAN_SELECT)
      reg_rdata <= scan_select_register;
    else if (reg_addr == `OFF_IRQ_STATUS)
      reg_rdata <= {30'h0, irq_status};
    else if (reg_addr == `OFF_IRQ_MASK)
      reg_rdata <= {30'h0, irq_mask};
    else if (reg_addr >= `OFF_SLOT_BASE && rd_offset[1:0] == 2'h0 &&
             rd_slot < 5'(`SLOT_COUNT))
      reg_rdata <= 32'(result_slot[rd_slot]);
    else
      reg_rdata <= 32'h00000000;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_reserved_bits_zero: assert property (
    reg_read && reg_addr == `OFF_CONTROL_TWO |=>
      (reg_rdata & ~(`CONTROL_WRITE_MASK | 32'h00000080)) == 32'h0)
    else $error("reserved control bits read nonzero");

  a_ref_external_pick: assert property (
    !reference_select[2] |=> ref_pos_external == $past(reference_select[1])
      && ref_neg_external == $past(reference_select[0]))
    else $error("reference outputs disagree with code");

  a_ref_reserved_rails: assert property (
    reference_select[2] |=> !ref_pos_external && !ref_neg_external)
    else $error("reserved reference code drove external pin");

  a_offset_cal_steer: assert property (
    offset_calibration_enable |=> sample_inputs_to_neg_ref)
    else $error("offset calibration did not steer inputs");

  a_fixed_channel_use: assert property (
    !input_scan_enable |=>
      primary_positive_input == $past(channel_select_register[4:0]))
    else $error("fixed channel not used without scan");

  a_scan_in_set: assert property (
    input_scan_enable && scan_select_register[scan_index] && conv_done |=>
      scan_select_register[scan_index] || $past(reg_write))
    else $error("scan left the scan set");

  a_channel_slot_map: assert property (
    slot_write && per_channel_buffer_enable |-> wr_slot == conv_channel)
    else $error("per-channel result in wrong slot");

  a_queue_restart: assert property (
    seq_end && !per_channel_buffer_enable |=> fill_ptr == 5'h00)
    else $error("queue did not restart at boundary");

  a_split_flag_toggle: assert property (
    seq_end && split_buffer_mode && !wr_control |=>
      buffer_fill_status != $past(buffer_fill_status))
    else $error("fill status did not toggle");

  a_single_flag_low: assert property (
    !split_buffer_mode ##1 !split_buffer_mode |-> !buffer_fill_status)
    else $error("fill status set outside split mode");

  a_split_half_range: assert property (
    slot_write && split_buffer_mode && !per_channel_buffer_enable |->
      (buffer_fill_status ? wr_slot >= 5'(`HALF_COUNT) :
       wr_slot < 5'(`HALF_COUNT)))
    else $error("split mode wrote wrong half");

  a_every_seq_irq: assert property (
    conv_done && sequences_per_interrupt == 4'h0 |=>
      irq_status[`IRQ_SEQ_DONE])
    else $error("code 0000 did not flag every sequence");

  a_seq_flag_set: assert property (
    seq_end |=> irq_status[`IRQ_SEQ_DONE])
    else $error("sequence boundary lost to a status clear");

  c_split_toggle: cover property (seq_end && split_buffer_mode);
  c_scan_step: cover property (input_scan_enable && conv_done);
  c_channel_write: cover property (slot_write && per_channel_buffer_enable);
  c_irq_raise: cover property (!irq ##1 irq);

endmodule

// *** verification/conv_core_model.sv ***
`timescale 1ns/1ps

module conv_core_model
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [4:0] chan,
  input wire logic [31:0] data,
  input wire logic [3:0] delay,
  output logic conv_done,
  output logic [4:0] conv_channel,
  output logic [31:0] conv_result
);
  logic busy;
  logic [3:0] wait_cnt;

  // outside the pulse the lines flip, except on the edge that takes start, so a stale value never reads as valid
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy <= 1'b0;
      wait_cnt <= 4'h0;
      conv_done <= 1'b0;
      conv_channel <= 5'h00;
      conv_result <= 32'h00000000;
    end
    else if (start)
    begin
      busy <= 1'b1;
      wait_cnt <= delay;
      conv_done <= 1'b0;
    end
    else if (busy && wait_cnt == 4'h0)
    begin
      busy <= 1'b0;
      conv_done <= 1'b1;
      conv_channel <= chan;
      conv_result <= data;
    end
    else
    begin
      wait_cnt <= wait_cnt - 4'h1;
      conv_done <= 1'b0;
      conv_channel <= ~conv_channel;
      conv_result <= ~conv_result;
    end
  end
endmodule

// *** verification/test_adc_result_buffer_control.sv ***
`timescale 1ns/1ps
`include "adc_result_buffer_params.svh"

module test_adc_result_buffer_control;
  logic clk, rstn, reg_write, reg_read, conv_done, start, irq;
  logic ref_pos_external, ref_neg_external, sample_inputs_to_neg_ref;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, conv_result, c_data, v;
  logic [4:0] conv_channel, c_chan, primary_positive_input, e;
  logic [3:0] c_delay;
  logic [31:0] slot_exp [22];
  int seed, bad_count, n_checks, i, j, k;

  adc_result_buffer_control dut
  (
    .clk(clk),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .conv_done(conv_done),
    .conv_channel(conv_channel),
    .conv_result(conv_result),
    .ref_pos_external(ref_pos_external),
    .ref_neg_external(ref_neg_external),
    .sample_inputs_to_neg_ref(sample_inputs_to_neg_ref),
    .primary_positive_input(primary_positive_input),
    .irq(irq)
  );

  conv_core_model core
  (
    .clk(clk),
    .rstn(rstn),
    .start(start),
    .chan(c_chan),
    .data(c_data),
    .delay(c_delay),
    .conv_done(conv_done),
    .conv_channel(conv_channel),
    .conv_result(conv_result)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [1:0] ref_exp(input logic [2:0] c);
    ref_exp = c[2] ? 2'b00 : {c[1], c[0]};
  endfunction

  // smallest step forward to a set mask bit, staying put on an empty mask
  function automatic logic [4:0] next_scan(input logic [31:0] m,
    input logic [4:0] c);
    int n;
    next_scan = c;
    for (n = 31; n >= 1; n--)
      if (m[(c + n) % 32])
        next_scan = 5'((c + n) % 32);
  endfunction

  task final_report;
    begin
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_checks++;
      if (got !== exp)
      begin
        bad_count++;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  task wait2;
    repeat (2) @(posedge clk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
      // idle edge so a following write never re-drives the strobe at once
      @(posedge clk);
    end
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d);
    begin
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
      @(posedge clk);
    end
  endtask

  // returns at the edge where the design takes the result
  task conv(input logic [4:0] ch, input logic [31:0] d);
    int n;
    begin
      c_chan <= ch;
      c_data <= d;
      c_delay <= 4'($random(seed) & 3);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      for (n = 0; n < 40 && conv_done !== 1'b1; n++)
        @(posedge clk);
      if (conv_done !== 1'b1)
      begin
        bad_count++;
        final_report;
      end
    end
  endtask

  initial
  begin
    seed = 25703;
    bad_count = 0;
    n_checks = 0;
    {rstn, reg_write, reg_read, start} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    c_chan = 5'h00;
    c_data = 32'h00000000;
    c_delay = 4'h0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(`OFF_CONTROL_TWO, v);
    chk(v, 32'h00000000);
    rd(8'h3C, v);
    chk(v, 32'h00000000);
    wr(`OFF_CONTROL_TWO, 32'hFFFFFFFF);
    rd(`OFF_CONTROL_TWO, v);
    chk(v, 32'h0000FC3E);
    for (i = 0; i < 8; i++)
    begin
      wr(`OFF_CONTROL_TWO, (i << 13) | ((i & 1) << 12));
      wait2;
      v = 32'(ref_exp(3'(i)));
      chk(32'({ref_pos_external, ref_neg_external}), v);
      chk(32'(sample_inputs_to_neg_ref), i & 1);
    end
    $display("control test done");
    wr(`OFF_IRQ_MASK, 32'h00000001);
    for (j = 0; j < 3; j++)
    begin
      k = (j == 0) ? 0 : (j == 1) ? 15 : ($random(seed) & 15);
      wr(`OFF_CONTROL_TWO, k << 2);
      wr(`OFF_IRQ_STATUS, 32'h00000003);
      for (i = 0; i < k; i++)
        conv(5'(i), $random(seed));
      wait2;
      chk(32'(irq), 0);
      conv(5'h01, $random(seed));
      wait2;
      chk(32'(irq), 1);
      wr(`OFF_IRQ_STATUS, 32'h00000001);
      wait2;
      chk(32'(irq), 0);
    end
    wr(`OFF_IRQ_MASK, 32'h00000000);
    wr(`OFF_CONTROL_TWO, 32'h00000000);
    conv(5'h02, 32'h00000000);
    wait2;
    chk(32'(irq), 0);
    wr(`OFF_IRQ_MASK, 32'h00000003);
    wait2;
    chk(32'(irq), 1);
    wr(`OFF_IRQ_STATUS, 32'h00000001);
    $display("interrupt test done");
    wr(`OFF_CONTROL_TWO, (2 << 2) | 2);
    for (j = 0; j < 4; j++)
    begin
      k = (j & 1) * 11;
      rd(`OFF_CONTROL_TWO, v);
      chk(32'(v[7]), j & 1);
      for (i = 0; i < 3; i++)
      begin
        slot_exp[k + i] = $random(seed);
        conv(5'(i), slot_exp[k + i]);
      end
      for (i = 0; i < 3; i++)
      begin
        rd(8'(`OFF_SLOT_BASE + 4 * (k + i)), v);
        chk(v, slot_exp[k + i]);
      end
    end
    $display("split buffer test done");
    wr(`OFF_CONTROL_TWO, 32'h00000800);
    for (j = 0; j < 5; j++)
    begin
      k = (j == 0) ? 21 : (($random(seed) & 31) % 22);
      slot_exp[k] = $random(seed);
      conv(5'(k), slot_exp[k]);
      rd(8'(`OFF_SLOT_BASE + 4 * k), v);
      chk(v, slot_exp[k]);
    end
    conv(5'h19, 32'h00000000);
    rd(`OFF_IRQ_STATUS, v);
    chk(v & 2, 2);
    $display("per channel test done");
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    wr(`OFF_CHANNEL_SELECT, 32'h00000005);
    wait2;
    chk(32'(primary_positive_input), 5);
    wr(`OFF_SCAN_SELECT, 32'h00000088);
    wr(`OFF_CONTROL_TWO, 32'h00000400);
    e = 5'h00;
    for (i = 0; i < 4; i++)
    begin
      wait2;
      chk(32'(primary_positive_input), 32'(e));
      conv(5'h00, $random(seed));
      e = next_scan(32'h00000088, e);
    end
    $display("scan test done");
    final_report;
  end
endmodule
